// [design/pebc_consts.vh]
// pebc_consts.vh: register offsets, field positions, reset values and
// timing counts for the port e bus control pin block.
// assumes: included by bare name from the design files under design/.
`ifndef PEBC_CONSTS_VH
`define PEBC_CONSTS_VH

// register byte offsets on the apb slave
`define PEBC_OFS_DATA      12'h008
`define PEBC_OFS_DIR       12'h009
`define PEBC_OFS_ASSIGN    12'h00a
`define PEBC_OFS_MODE      12'h00b
`define PEBC_OFS_EBCTL     12'h00e
`define PEBC_OFS_IRQCTL    12'h01e
`define PEBC_OFS_BUSCMD    12'h040
`define PEBC_OFS_STATUS    12'h044

// field positions in the assignment register
`define PEBC_ASG_PIPE_STATUS_OUTPUT_ENABLE     5
`define PEBC_ASG_BUS_CLOCK_DISABLE     4
`define PEBC_ASG_LSTRE     3
`define PEBC_ASG_RDWE      2
// field positions in the mode register
`define PEBC_MODE_INTERNAL_VISIBILITY     3
`define PEBC_MODE_TAG      2
// field positions in the external bus control register
`define PEBC_EBC_BUS_CLOCK_STRETCH_ENABLE      0
// field positions in the irq control register
`define PEBC_IRQ_EDGE      7
`define PEBC_IRQ_EN        6

// reset values
`define PEBC_RST_DATA      8'h00
`define PEBC_RST_DIR       8'h00
`define PEBC_RST_ASSIGN    8'h10
`define PEBC_RST_MODE      8'h00
`define PEBC_RST_EBCTL     8'h00
`define PEBC_RST_IRQCTL    8'h40

// mode encodings held in the mode register bits 7:5
`define PEBC_MD_PERIPH     3'h2
`define PEBC_MD_EMU_NARROW 3'h5
`define PEBC_MD_EXP_WIDE   3'h7

// bus clock: extra high-phase cycles when stretched
`define PEBC_STRETCH_CYC   4'h3

`endif

// [design/pebc_sync.v]
// pebc_sync.v: two-flop synchroniser for a group of pin inputs.
// assumes: inputs are asynchronous to clk_sys; outputs read by core logic.
`timescale 1ns/1ps
module pebc_sync #(
  parameter W = 8                  // number of bits synchronised
) (
  input  wire         clk_sys,     // system clock
  input  wire [W-1:0] din,         // raw pin levels
  output wire [W-1:0] dout         // synchronised levels
);
  reg [W-1:0] meta_q;              // first stage, read only by second
  reg [W-1:0] sync_q;              // second stage

  // two flops in series; no reset, so the pin levels are already
  // settled when reset is released and the mode pin is captured
  always @(posedge clk_sys) begin
    meta_q <= din;
    sync_q <= meta_q;
  end

  assign dout = sync_q;
endmodule

// [design/pebc_top.v]
// pebc_top.v: port e bus control pin mux with apb register slave.
// assumes: pins are asynchronous and resolved by the bench from the
// enables; the bus engine supplies access requests and pipe status.
//
// Functional notes
// - mode_select_a pin captured at reset release
// - bits 6..2 are gpio when unclaimed
// - pipe status 0 on bit5 when enabled
// - bus clock free-running or per-access stretched
// - bus clock mode from two control bits
// - low byte strobe low with valid low data
// - read/write output, input in peripheral mode
// - bit1 input-only, readable with irq enabled
// - irq selectable level or edge
// - pipe status 1 on bit6 when enabled
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "pebc_consts.vh"
module pebc_top (
  input  wire        clk_sys,        // system clock, 200 mhz
  input  wire        nrst,           // synchronous reset, active low
  input  wire        psel,           // apb select
  input  wire        penable,        // apb enable
  input  wire        pwrite,         // apb direction
  input  wire [11:0] paddr,          // apb byte address
  input  wire [31:0] pwdata,         // apb write data
  output wire        pready,         // apb ready
  output reg  [31:0] prdata,         // apb read data
  output wire        pslverr,        // apb error on unmapped address
  input  wire [1:0]  pipe_status,    // instruction pipe status from core
  input  wire        acc_req,        // visible access pulse from core
  input  wire        acc_slow,       // access needs stretched high phase
  input  wire        acc_write,      // access direction, 1 = write
  input  wire        acc_low_byte,   // access carries low byte data
  input  wire [6:1]  port_e_in,      // pin levels bits 6..1
  output reg  [6:2]  port_e_out,     // pin drive values bits 6..2
  output reg  [6:2]  port_e_oe,      // pin enables, high while driving
  output reg         irq_req,        // maskable interrupt request to core
  output reg         tag_low_half,   // low half tag captured
  output reg         transfer_size_byte, // tester size, 1 = 8-bit
  output reg         tester_write_n, // tester direction level
  output reg         mode_select_a   // captured mode select a
);
  // register bank
  reg [7:0] data_q;                  // port_e_data
  reg [7:0] dir_q;                   // port_e_direction
  reg [7:0] assign_q;                // port_e_assignment
  reg [7:0] mode_q;                  // mode register
  reg [7:0] ebctl_q;                 // external_bus_control
  reg [7:0] irqctl_q;                // irq control
  reg       nrst_q;                  // delayed reset for release edge
  reg       bus_timing_clock_q;                  // bus_timing_clock level
  reg       bus_timing_clock_d;
  reg [3:0] hcnt_q;                  // stretch counter
  reg [3:0] hcnt_d;
  reg [1:0] st_q;                    // per-access clock state
  reg [1:0] st_d;
  reg       irq_prev_q;              // previous irq level for edges
  reg       irq_edge_q;              // sticky edge flag

  wire [6:1] pin_s;                  // synchronised pins
  wire       wr_en;
  wire       rd_en;
  wire       periph;
  wire       tag_mode;
  wire       clk_free;
  wire       irq_lvl;

  localparam [1:0] ST_IDLE = 2'h0;   // clock idle high
  localparam [1:0] ST_LOW  = 2'h1;   // low phase
  localparam [1:0] ST_HIGH = 2'h2;   // high phase, maybe stretched

  pebc_sync #(.W(6)) u_sync (
    .clk_sys (clk_sys),
    .din     (port_e_in),
    .dout    (pin_s)
  );

  assign pready   = 1'b1;            // zero wait state slave
  assign wr_en    = psel & penable & pwrite;
  // read data is loaded in the setup phase so it stands in the access
  assign rd_en    = psel & ~penable & ~pwrite;
  assign periph   = (mode_q[7:5] == `PEBC_MD_PERIPH);
  assign tag_mode = ((mode_q[7:5] == `PEBC_MD_EXP_WIDE) |
                     (mode_q[7:5] == `PEBC_MD_EMU_NARROW)) &
                    mode_q[`PEBC_MODE_TAG] &
                    assign_q[`PEBC_ASG_LSTRE];
  // free run unless disabled or internal accesses are visible
  assign clk_free = ~mode_q[`PEBC_MODE_INTERNAL_VISIBILITY] &
                    ~assign_q[`PEBC_ASG_BUS_CLOCK_DISABLE];
  assign irq_lvl  = ~pin_s[1];       // request is active low

  // address decode for error flag
  reg mapped;
  always @* begin
    if (paddr == `PEBC_OFS_DATA) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_DIR) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_ASSIGN) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_MODE) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_EBCTL) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_IRQCTL) begin
      mapped = 1'b1;
    end else if (paddr == `PEBC_OFS_STATUS) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  assign pslverr = psel & penable & ~mapped;

  // register writes and mode capture
  always @(posedge clk_sys) begin
    if (!nrst) begin
      data_q   <= `PEBC_RST_DATA;
      dir_q    <= `PEBC_RST_DIR;
      assign_q <= `PEBC_RST_ASSIGN;
      mode_q   <= `PEBC_RST_MODE;
      ebctl_q  <= `PEBC_RST_EBCTL;
      irqctl_q <= `PEBC_RST_IRQCTL;
      nrst_q   <= 1'b0;
      mode_select_a <= 1'b0;
    end else begin
      nrst_q <= 1'b1;
      if (!nrst_q) begin
        mode_select_a <= pin_s[5];
        mode_q[5]     <= pin_s[5];
      end
      if (wr_en) begin
        if (paddr == `PEBC_OFS_DATA) begin
          data_q <= pwdata[7:0];
        end else if (paddr == `PEBC_OFS_DIR) begin
          dir_q <= pwdata[7:0];
        end else if (paddr == `PEBC_OFS_ASSIGN) begin
          assign_q <= pwdata[7:0];
        end else if (paddr == `PEBC_OFS_MODE) begin
          mode_q <= pwdata[7:0];
        end else if (paddr == `PEBC_OFS_EBCTL) begin
          ebctl_q <= pwdata[7:0];
        end else if (paddr == `PEBC_OFS_IRQCTL) begin
          irqctl_q <= pwdata[7:0];
        end
      end
    end
  end

  // read mux; bit1 always shows the pin level
  always @(posedge clk_sys) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == `PEBC_OFS_DATA) begin
        // bit 7 belongs to another block and reads as zero here
        prdata <= {24'h000000, 1'b0,
                   (dir_q[6:2] & data_q[6:2]) | (~dir_q[6:2] & pin_s[6:2]),
                   pin_s[1], 1'b0};
      end else if (paddr == `PEBC_OFS_DIR) begin
        prdata <= {24'h000000, dir_q[7:2], 2'h0};
      end else if (paddr == `PEBC_OFS_ASSIGN) begin
        prdata <= {24'h000000, assign_q};
      end else if (paddr == `PEBC_OFS_MODE) begin
        prdata <= {24'h000000, mode_q};
      end else if (paddr == `PEBC_OFS_EBCTL) begin
        prdata <= {24'h000000, ebctl_q};
      end else if (paddr == `PEBC_OFS_IRQCTL) begin
        prdata <= {24'h000000, irqctl_q};
      end else if (paddr == `PEBC_OFS_STATUS) begin
        prdata <= {26'h0, irq_req, tag_low_half, transfer_size_byte,
                   tester_write_n, bus_timing_clock_q, mode_select_a};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // per-access bus clock state machine
  always @* begin
    st_d   = st_q;
    hcnt_d = hcnt_q;
    bus_timing_clock_d = bus_timing_clock_q;
    if (clk_free) begin
      st_d   = ST_IDLE;
      bus_timing_clock_d = ~bus_timing_clock_q;
    end else begin
      case (st_q)
        ST_IDLE: begin
          bus_timing_clock_d = 1'b1;
          if (acc_req) begin
            st_d   = ST_LOW;
            bus_timing_clock_d = 1'b0;
          end
        end
        ST_LOW: begin
          st_d   = ST_HIGH;
          bus_timing_clock_d = 1'b1;
          hcnt_d = (acc_slow & ebctl_q[`PEBC_EBC_BUS_CLOCK_STRETCH_ENABLE]) ?
                   `PEBC_STRETCH_CYC : 4'h0;
        end
        ST_HIGH: begin
          if (hcnt_q == 4'h0) begin
            st_d = ST_IDLE;
          end else begin
            hcnt_d = hcnt_q - 4'h1;
          end
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // bus clock, tag capture and irq flops
  always @(posedge clk_sys) begin
    if (!nrst) begin
      st_q         <= ST_IDLE;
      hcnt_q       <= 4'h0;
      bus_timing_clock_q       <= 1'b1;
      tag_low_half <= 1'b0;
      irq_prev_q   <= 1'b0;
      irq_edge_q   <= 1'b0;
      irq_req      <= 1'b0;
      transfer_size_byte <= 1'b0;
      tester_write_n     <= 1'b1;
    end else begin
      st_q   <= st_d;
      hcnt_q <= hcnt_d;
      bus_timing_clock_q <= bus_timing_clock_d;
      // sample tag at the falling edge of the bus clock
      if (tag_mode & bus_timing_clock_q & ~bus_timing_clock_d) begin
        tag_low_half <= ~pin_s[3];
      end
      if (periph) begin
        transfer_size_byte <= pin_s[3];
        tester_write_n     <= pin_s[2];
      end
      irq_prev_q <= irq_lvl;
      // edge flag: set wins over the clear when irq is served
      if (irq_lvl & ~irq_prev_q) begin
        irq_edge_q <= 1'b1;
      end else if (wr_en & (paddr == `PEBC_OFS_IRQCTL)) begin
        irq_edge_q <= 1'b0;
      end
      irq_req <= irqctl_q[`PEBC_IRQ_EN] &
                 (irqctl_q[`PEBC_IRQ_EDGE] ? irq_edge_q : irq_lvl);
    end
  end

  // pin multiplexing for bits 6..2
  always @(posedge clk_sys) begin
    if (!nrst) begin
      port_e_out <= 5'h00;
      port_e_oe  <= 5'h00;
    end else begin
      port_e_out <= data_q[6:2];
      port_e_oe  <= dir_q[6:2];
      if (assign_q[`PEBC_ASG_PIPE_STATUS_OUTPUT_ENABLE]) begin
        port_e_out[6] <= pipe_status[1];
        port_e_oe[6]  <= 1'b1;
        port_e_out[5] <= pipe_status[0];
        port_e_oe[5]  <= 1'b1;
      end
      if (~assign_q[`PEBC_ASG_BUS_CLOCK_DISABLE] | mode_q[`PEBC_MODE_INTERNAL_VISIBILITY]) begin
        port_e_out[4] <= bus_timing_clock_d;
        port_e_oe[4]  <= 1'b1;
      end
      if (periph) begin
        port_e_oe[3] <= 1'b0;
        port_e_oe[2] <= 1'b0;
      end else begin
        if (assign_q[`PEBC_ASG_LSTRE] & ~tag_mode) begin
          port_e_out[3] <= ~(acc_low_byte & ~st_d[1] & st_d[0]) &
                           ~(acc_low_byte & st_d[1]);
          port_e_oe[3]  <= 1'b1;
        end
        if (assign_q[`PEBC_ASG_RDWE]) begin
          port_e_out[2] <= ~acc_write;
          port_e_oe[2]  <= 1'b1;
        end
      end
    end
  end
endmodule

// [verif/pebc_ext_model.sv]
// pebc_ext_model.sv: pins outside the device (tester side).
// assumes: bench sets ext_en and ext_val; device wins when enabled.
`timescale 1ns/1ps
module pebc_ext_model (
  input  wire       clk_sys,
  input  wire [6:2] port_e_out,
  input  wire [6:2] port_e_oe,
  input  wire [6:1] ext_en,
  input  wire [6:1] ext_val,
  output wire [6:1] port_e_in
);
  reg  [6:1] flt_q = 6'h00;        // undriven lines wander
  // bit 1 is never driven; an unknown enable before the first clock
  // edge counts as released so the tester levels reach the pins
  wire [6:1] oe = {port_e_oe[6] === 1'b1, port_e_oe[5] === 1'b1,
                   port_e_oe[4] === 1'b1, port_e_oe[3] === 1'b1,
                   port_e_oe[2] === 1'b1, 1'b0};
  // wander every cycle so a floating line is never trusted
  always @(posedge clk_sys) flt_q <= ~flt_q;
  // tester drives size, tag and direction where device does not
  assign port_e_in = (oe & {port_e_out, 1'b0})
    | (~oe & ext_en & ext_val) | (~oe & ~ext_en & flt_q);
endmodule

// [verif/pebc_top_sva.sv]
// pebc_top_sva.sv: port checks for the port e pin mux.
// assumes: bound into pebc_top; control writes shadowed here.
`timescale 1ns/1ps
module pebc_top_sva (
  input wire        clk_sys,
  input wire        nrst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [1:0]  pipe_status,
  input wire        acc_req,
  input wire        acc_low_byte,
  input wire [6:1]  port_e_in,
  input wire [6:2]  port_e_out,
  input wire [6:2]  port_e_oe,
  input wire        irq_req,
  input wire        mode_select_a
);
  reg  [7:0] asg_q;                      // assignment shadow
  reg  [7:0] irq_q;                      // irq control shadow
  reg        vis_q;                      // visibility shadow
  wire       wr = psel & penable & pwrite; // write taken
  // follow control writes
  always @(posedge clk_sys) begin
    if (!nrst) begin
      asg_q <= 8'h10;
      irq_q <= 8'h40;
      vis_q <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h00a) asg_q <= pwdata[7:0];
      if (paddr == 12'h01e) irq_q <= pwdata[7:0];
      if (paddr == 12'h00b) vis_q <= pwdata[3];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_MODE_HOLD: assert property (
    $past(nrst, 2) && $past(nrst) |-> $stable(mode_select_a))
    else $error("mode select a moved after capture");
  AST_PIPE0: assert property (
    (asg_q[5]) [*2] |-> port_e_oe[5]
    && port_e_out[5] == $past(pipe_status[0]))
    else $error("pipe status 0 not on bit 5");
  AST_PIPE1: assert property (
    (asg_q[5]) [*2] |-> port_e_oe[6]
    && port_e_out[6] == $past(pipe_status[1]))
    else $error("pipe status 1 not on bit 6");
  AST_FREE_RUN: assert property (
    (!asg_q[4] && !vis_q) [*3] |-> port_e_out[4] != $past(port_e_out[4]))
    else $error("bus clock not free running");
  AST_IDLE_HIGH: assert property (
    (vis_q && !acc_req) [*8] |-> port_e_out[4])
    else $error("bus clock not high when idle");
  AST_ACC_LOW: assert property (
    vis_q && acc_req |-> ##[1:2] !port_e_out[4])
    else $error("no low phase for access");
  AST_STROBE: assert property (
    vis_q && asg_q[3] && acc_req && acc_low_byte
    |-> ##[1:2] !port_e_out[3])
    else $error("low strobe missing");
  AST_IRQ_LVL: assert property (
    (irq_q[7:6] == 2'b01 && !port_e_in[1]) [*6] |-> irq_req)
    else $error("level irq not raised");
  AST_READY: assert property (psel |-> pready)
    else $error("ready low");
endmodule

bind pebc_top pebc_top_sva sva_u (.*);

// [verif/tb_port_e_bus_control_pins.sv]
// tb_port_e_bus_control_pins.sv: self-checking bench for pebc_top.
// assumes: pebc_ext_model on the pins; bench is the apb master.
`timescale 1ns/1ps
`include "pebc_consts.vh"
module tb_port_e_bus_control_pins;
  reg         clk_sys, nrst, psel, penable, pwrite, se, pv;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [1:0]  pipe_status;
  reg         acc_req, acc_slow, acc_write, acc_low_byte;
  reg  [6:1]  ext_en, ext_val;
  reg  [15:0] lf;
  integer     error_cnt, comparisons, i, lo, tg;
  wire        pready, pslverr, irq_req, tag_low_half;
  wire        transfer_size_byte, tester_write_n, mode_select_a;
  wire [31:0] prdata;
  wire [6:1]  port_e_in;
  wire [6:2]  port_e_out, port_e_oe;
  pebc_top       dut_u (.*);
  pebc_ext_model ext_u (.*);
  // next random value
  function [15:0] nx(input [15:0] v);
    nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // strobe low span: low phase, high phase, stretch when slow and stretch enabled
  function integer strb_len(input slow, input str);
    strb_len = 2 + ((slow && str) ? `PEBC_STRETCH_CYC : 0);
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("Error %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // one apb transfer; read data kept in rd, error in se
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1'b1;
      // wait for the edge at which the access phase is answered
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      // take the answer at that same edge, only then release
      se = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task wt(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task pin1(input v, input integer k);
    begin
      @(posedge clk_sys) ext_val[1] <= v;
      wt(k);
    end
  endtask
  // count low and toggling cycles of one output bit
  task watch(input integer len, input integer b);
    begin
      lo = 0;
      tg = 0;
      pv = port_e_out[b];
      repeat (len) begin
        @(negedge clk_sys);
        lo = lo + (port_e_out[b] === 1'b0);
        tg = tg + (port_e_out[b] !== pv);
        pv = port_e_out[b];
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    tally_and_finish;
  end
  initial begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = 0;
    {pipe_status, acc_req, acc_slow, acc_write, acc_low_byte} = 0;
    error_cnt = 0;
    comparisons = 0;
    lf = 16'h0041;
    ext_en = 6'h3f;
    ext_val = {1'b0, lf[0], 4'hf};
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    wt(3);
    chk(mode_select_a, lf[0], "mode_a");
    apb(0, 12'h00a, 0);
    chk(rd, 32'h10, "assign");
    apb(0, 12'h004, 0);
    chk(se, 1, "unmap");
    apb(1, 12'h00b, 0);
    apb(1, 12'h009, 32'h1c);
    for (i = 0; i < 4; i = i + 1) begin
      lf = nx(lf);
      @(posedge clk_sys) pipe_status <= lf[11:10];
      ext_val[1] <= lf[8];
      apb(1, 12'h008, lf);
      apb(1, 12'h00a, {i[0], 5'h10});
      wt(4);
      apb(0, 12'h008, 0);
      chk(rd[1], lf[8], "pin1");
      chk(port_e_oe, {{2{i[0]}}, 3'h7}, "oe");
      chk(port_e_out[4:2], lf[4:2], "gpio");
      if (i[0]) chk(port_e_out[6:5], lf[11:10], "pipe");
    end
    $display("test gpio done");
    apb(1, 12'h00a, 0);
    // let the free clock start before its toggles are counted
    wt(1);
    watch(16, 4);
    chk(tg, 16, "free");
    apb(1, 12'h00b, 32'h08);
    // strobe and read/write outputs both enabled
    apb(1, 12'h00a, 32'h1c);
    for (i = 0; i < 5; i = i + 1) begin
      apb(1, 12'h00e, i[1]);
      @(posedge clk_sys) acc_req <= 1'b1;
      acc_slow <= i[0];
      acc_low_byte <= (i < 4);
      acc_write <= lf[i];
      fork
        @(posedge clk_sys) acc_req <= 1'b0;
        watch(14, 3);
      join
      chk(lo, (i < 4) ? strb_len(i[0], i[1]) : 0, "strobe");
      chk({port_e_oe[2], port_e_out[2]}, {1'b1, !lf[i]}, "rw_out");
    end
    $display("test bus clock done");
    pin1(0, 8);
    chk(irq_req, 1, "irq_lv");
    pin1(1, 8);
    chk(irq_req, 0, "irq_lv");
    apb(1, 12'h01e, 32'hc0);
    pin1(0, 6);
    pin1(1, 8);
    chk(irq_req, 1, "irq_edge");
    apb(1, 12'h01e, 32'hc0);
    wt(4);
    chk(irq_req, 0, "irq_clr");
    $display("test irq done");
    apb(1, 12'h00b, 32'h40);
    apb(1, 12'h009, 0);
    lf = nx(lf);
    @(posedge clk_sys) ext_val[3:2] <= lf[1:0];
    wt(6);
    chk(transfer_size_byte, lf[1], "size");
    chk(tester_write_n, lf[0], "rw_in");
    chk(port_e_oe[2], 0, "rw_oe");
    $display("test tester done");
    // expanded wide with tagging, strobe enabled, free bus clock
    apb(1, 12'h00b, 32'he4);
    apb(1, 12'h00a, 32'h08);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk_sys) ext_val[3] <= i[0];
      wt(8);
      chk({port_e_oe[3], tag_low_half}, {1'b0, !i[0]}, "tag_lo");
    end
    $display("test tag done");
    tally_and_finish;
  end
endmodule
